// file: logic/alarm_mask_pkg.sv
// Purpose: shared constants and carriers for the alarm enable mask block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: offsets are word indices; the byte address is four times the index
package alarm_mask_pkg;
  localparam logic [7:0] OFS_MONITOR_IRQ_ENABLE = 8'hf8;
  localparam logic [7:0] OFS_RESERVED_A = 8'hf9;
  localparam logic [7:0] OFS_QUICKTRIP_ENABLE = 8'hfa;
  localparam logic [7:0] OFS_RESERVED_B = 8'hfb;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h01;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
  localparam logic [7:0] OFS_STATE = 8'h03;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] QT_VALID_BITS = 8'h0b;
  localparam logic [7:0] SHARED_BITS = 8'hf0;
  localparam int CTRL_TX_SEL_BIT = 0;
  localparam int CTRL_BANK_BIT = 1;
  localparam int CTRL_LOW_PW_BIT = 2;
  localparam int CTRL_HIGH_PW_BIT = 3;
  localparam int CTRL_READ_GRANT_BIT = 4;
  localparam int CTRL_RW_GRANT_BIT = 5;
  localparam int CTRL_TABLE_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic temperature_high_alarm;
    logic temperature_low_alarm;
    logic supply_high_alarm;
    logic supply_low_alarm;
    logic bias_high_alarm;
    logic bias_low_alarm;
    logic power_high_alarm;
    logic power_low_alarm;
  } monitor_flags_t;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic high_bias_alarm;
    logic unused_mid;
    logic tx_power_high_alarm;
    logic tx_power_low_alarm;
  } quicktrip_flags_t;
endpackage : alarm_mask_pkg

// file: logic/alarm_enable_masks.sv
// Purpose: alarm enable masks gating monitor alarms and quick-trip alarms
// Assumes: alarm flags arrive from logic on CLK_SYS; AXI4-Lite slave
// Notes: password state and table window come from a control register
//
// The AXI4-Lite register port was left to the implementer.
module alarm_enable_masks
  import alarm_mask_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [9:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [9:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire monitor_flags_t MONITOR_ALARMS_ONE,
  input wire monitor_flags_t MONITOR_ALARMS_TWO,
  input wire quicktrip_flags_t QUICKTRIP_ALARMS_ONE,
  input wire quicktrip_flags_t QUICKTRIP_ALARMS_TWO,
  output logic TX_FAULT_INTERRUPT_ONE,
  output logic TX_FAULT_INTERRUPT_TWO,
  output logic SHUTDOWN_GATE_ONE,
  output logic SHUTDOWN_GATE_TWO,
  output logic IRQ
);
  logic [7:0] control;
  logic [3:0] shared_en;
  logic [3:0] split_en [2];
  logic [7:0] qt_en [2];
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held, w_held;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] events;
  logic wr_go, rd_go;
  logic tx;
  logic can_read, can_write;
  logic in_window;
  logic [7:0] mon_en_one, mon_en_two;
  logic [7:0] ar_idx;
  logic [7:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;
  logic [3:0] outs;
  logic [3:0] prev_out;

  // decode: the two enable registers, and every index the block answers
  function automatic logic is_mask(input logic [7:0] idx);
    is_mask = idx == OFS_MONITOR_IRQ_ENABLE || idx == OFS_QUICKTRIP_ENABLE;
  endfunction : is_mask

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = is_mask(idx) || idx == OFS_RESERVED_A || idx == OFS_RESERVED_B
      || idx <= OFS_STATE;
  endfunction : is_mapped

  // combine shared and per-transmitter halves into the visible register
  function automatic logic [7:0] mon_view(input logic [3:0] sh, input logic [3:0] sp);
    mon_view = {sh, sp};
  endfunction : mon_view

  assign tx = control[CTRL_TX_SEL_BIT];
  assign ar_idx = ARADDR[9:2];
  // masks answer only while the selected table is the bank they live in
  assign in_window = control[CTRL_BANK_BIT] == control[CTRL_TABLE_BIT];
  // password checks for both enable registers
  assign can_read = control[CTRL_HIGH_PW_BIT] | (control[CTRL_LOW_PW_BIT]
    & (control[CTRL_READ_GRANT_BIT] | control[CTRL_RW_GRANT_BIT]));
  assign can_write = control[CTRL_HIGH_PW_BIT]
    | (control[CTRL_LOW_PW_BIT] & control[CTRL_RW_GRANT_BIT]);
  assign mon_en_one = mon_view(shared_en, split_en[0]);
  assign mon_en_two = mon_view(shared_en, split_en[1]);

  // handshake: accept each channel once, answer after both held
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign ARREADY = !RVALID;
  assign wr_go = aw_held && w_held && !BVALID;
  assign rd_go = ARVALID && ARREADY;

  // capture write address and write data in either order
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        awaddr_q <= AWADDR[9:2];
      end
      else if (wr_go)
      begin
        aw_held <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      else if (wr_go)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // write response code
  always_comb
  begin
    next_bresp = RESP_DECERR;
    if (is_mask(awaddr_q))
    begin
      next_bresp = (can_write && in_window) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (is_mapped(awaddr_q))
    begin
      next_bresp = RESP_OKAY;
    end
  end

  // write response channel
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      BVALID <= 1'b1;
      BRESP <= next_bresp;
    end
    else if (BREADY)
    begin
      BVALID <= 1'b0;
    end
  end

  // mask storage: shared upper nibble, split lower nibble, per-tx quick-trip
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      shared_en <= RESET_ENABLE[7:4];
      split_en[0] <= RESET_ENABLE[3:0];
      split_en[1] <= RESET_ENABLE[3:0];
      qt_en[0] <= RESET_ENABLE;
      qt_en[1] <= RESET_ENABLE;
      control <= 8'h00;
      irq_mask <= 4'h0;
    end
    else if (wr_go && wstrb_q[0])
    begin
      if (awaddr_q == OFS_MONITOR_IRQ_ENABLE && can_write && in_window)
      begin
        shared_en <= wdata_q[7:4];
        split_en[tx] <= wdata_q[3:0];
      end
      else if (awaddr_q == OFS_QUICKTRIP_ENABLE && can_write && in_window)
      begin
        qt_en[tx] <= wdata_q[7:0] & QT_VALID_BITS;
      end
      else if (awaddr_q == OFS_CONTROL)
      begin
        control <= {1'b0, wdata_q[6:0]};
      end
      else if (awaddr_q == OFS_IRQ_MASK)
      begin
        irq_mask <= wdata_q[3:0];
      end
    end
  end

  // gated outputs: each enable bit passes its matching alarm
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      TX_FAULT_INTERRUPT_ONE <= 1'b0;
      TX_FAULT_INTERRUPT_TWO <= 1'b0;
      SHUTDOWN_GATE_ONE <= 1'b0;
      SHUTDOWN_GATE_TWO <= 1'b0;
    end
    else
    begin
      TX_FAULT_INTERRUPT_ONE <= |(MONITOR_ALARMS_ONE & mon_en_one);
      TX_FAULT_INTERRUPT_TWO <= |(MONITOR_ALARMS_TWO & mon_en_two);
      SHUTDOWN_GATE_ONE <= |(QUICKTRIP_ALARMS_ONE & qt_en[0] & QT_VALID_BITS);
      SHUTDOWN_GATE_TWO <= |(QUICKTRIP_ALARMS_TWO & qt_en[1] & QT_VALID_BITS);
    end
  end

  // rising edges of the four gated outputs are interrupt events
  assign outs = {SHUTDOWN_GATE_TWO, SHUTDOWN_GATE_ONE, TX_FAULT_INTERRUPT_TWO,
    TX_FAULT_INTERRUPT_ONE};
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      prev_out <= 4'h0;
    end
    else
    begin
      prev_out <= outs;
    end
  end
  assign events = outs & ~prev_out;

  // sticky status, cleared by reading it; a new event wins over the clear
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      irq_status <= 4'h0;
    end
    else
    begin
      irq_status <= ((rd_go && ar_idx == OFS_IRQ_STATUS) ? 4'h0 : irq_status) | events;
    end
  end
  assign IRQ = |(irq_status & irq_mask);

  // read data mux; reserved indices fall through and read zero
  always_comb
  begin
    next_rdata = 8'h00;
    next_rresp = RESP_OKAY;
    if (!is_mapped(ar_idx))
    begin
      next_rresp = RESP_DECERR;
    end
    else if (is_mask(ar_idx) && !(can_read && in_window))
    begin
      next_rresp = RESP_SLVERR;
    end
    else if (ar_idx == OFS_MONITOR_IRQ_ENABLE)
    begin
      next_rdata = tx ? mon_en_two : mon_en_one;
    end
    else if (ar_idx == OFS_QUICKTRIP_ENABLE)
    begin
      next_rdata = qt_en[tx];
    end
    else if (ar_idx == OFS_CONTROL)
    begin
      next_rdata = control;
    end
    else if (ar_idx == OFS_IRQ_STATUS)
    begin
      next_rdata = {4'h0, irq_status};
    end
    else if (ar_idx == OFS_IRQ_MASK)
    begin
      next_rdata = {4'h0, irq_mask};
    end
    else if (ar_idx == OFS_STATE)
    begin
      next_rdata = {4'h0, outs};
    end
  end

  // read data channel
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      RVALID <= 1'b1;
      RDATA <= {24'h00_0000, next_rdata};
      RRESP <= next_rresp;
    end
    else if (RREADY)
    begin
      RVALID <= 1'b0;
    end
  end

  property p_fault_one;
    @(posedge CLK_SYS) disable iff (RST)
    TX_FAULT_INTERRUPT_ONE == $past(|(MONITOR_ALARMS_ONE & mon_en_one));
  endproperty
  a_fault_one: assert property (p_fault_one) else $error("fault one mismatch");
  property p_temp_high_gate;
    @(posedge CLK_SYS) disable iff (RST)
    (MONITOR_ALARMS_ONE.temperature_high_alarm && shared_en[3]) |=> TX_FAULT_INTERRUPT_ONE;
  endproperty
  a_temp_high_gate: assert property (p_temp_high_gate) else $error("temp high lost");
  property p_shared_equal;
    @(posedge CLK_SYS) disable iff (RST)
    mon_en_one[7:4] == mon_en_two[7:4];
  endproperty
  a_shared_equal: assert property (p_shared_equal) else $error("shared bits differ");
  property p_gate_two;
    @(posedge CLK_SYS) disable iff (RST)
    SHUTDOWN_GATE_TWO == $past(|(QUICKTRIP_ALARMS_TWO & qt_en[1] & QT_VALID_BITS));
  endproperty
  a_gate_two: assert property (p_gate_two) else $error("gate two mismatch");
  property p_qt_reserved;
    @(posedge CLK_SYS) disable iff (RST)
    (qt_en[0] & ~QT_VALID_BITS) == 8'h00 && (qt_en[1] & ~QT_VALID_BITS) == 8'h00;
  endproperty
  a_qt_reserved: assert property (p_qt_reserved) else $error("reserved bit stored");
  property p_no_write_locked;
    @(posedge CLK_SYS) disable iff (RST)
    (wr_go && !can_write) |=> ($stable(shared_en) && $stable(qt_en[0]) && $stable(qt_en[1]));
  endproperty
  a_no_write_locked: assert property (p_no_write_locked) else $error("locked write");
  property p_rsvd_read;
    @(posedge CLK_SYS) disable iff (RST)
    (rd_go && ar_idx == OFS_RESERVED_A) |=> (RVALID && RDATA == 32'h0000_0000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read nonzero");
  property p_irq_sticky;
    @(posedge CLK_SYS) disable iff (RST)
    !(rd_go && ar_idx == OFS_IRQ_STATUS) |=> &(irq_status | ~$past(irq_status));
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost");
endmodule : alarm_enable_masks

// file: tb/mgmt_host.sv
// Purpose: register bus host model driving the alarm mask block
// Assumes: one write and one read at most under way, single clock
// Notes: payloads are inverted once taken so stale values never pass
module mgmt_host
(
  input wire logic clk,
  output logic [9:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [9:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // handshakes are judged at the falling edge, acted on at the rising edge
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    logic b_done;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_done = 1'b0;
    while (!b_done)
    begin
      @(negedge clk);
      aw_done = awvalid && awready;
      w_done = wvalid && wready;
      b_done = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (aw_done) awvalid <= 1'b0;
      if (aw_done) awaddr <= ~a;
      if (w_done) wvalid <= 1'b0;
      if (w_done) wdata <= ~d;
    end
    bready <= 1'b0;
  endtask : wr

  // read with rready held until the answer is seen
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_done;
    logic r_done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_done = 1'b0;
    while (!r_done)
    begin
      @(negedge clk);
      ar_done = arvalid && arready;
      r_done = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_done) arvalid <= 1'b0;
      if (ar_done) araddr <= ~a;
    end
    rready <= 1'b0;
  endtask : rd
endmodule : mgmt_host

// file: tb/tb_top.sv
// Purpose: self-checking bench for the alarm enable mask block
// Assumes: host model speaks the register bus, bench drives alarm levels
// Notes: scenarios run in sequence from one main process
module tb_top
  import alarm_mask_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] mon1 = 8'h00, mon2 = 8'h00, qt1 = 8'h00, qt2 = 8'h00;
  logic fault1, fault2, gate1, gate2, irq;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  mgmt_host mgmt_host_inst (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  alarm_enable_masks alarm_enable_masks_inst (.CLK_SYS(clk), .RST(rst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .MONITOR_ALARMS_ONE(monitor_flags_t'(mon1)),
    .MONITOR_ALARMS_TWO(monitor_flags_t'(mon2)), .QUICKTRIP_ALARMS_ONE(quicktrip_flags_t'(qt1)),
    .QUICKTRIP_ALARMS_TWO(quicktrip_flags_t'(qt2)), .TX_FAULT_INTERRUPT_ONE(fault1),
    .TX_FAULT_INTERRUPT_TWO(fault2), .SHUTDOWN_GATE_ONE(gate1), .SHUTDOWN_GATE_TWO(gate2),
    .IRQ(irq));

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bus wrappers comparing the response and read data
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    mgmt_host_inst.wr({a, 2'b00}, d, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    mgmt_host_inst.rd({a, 2'b00}, d, r);
    chk("rresp", {30'h0, r}, {30'h0, er});
    if (er === RESP_OKAY) chk("rdata", d, ed);
  endtask : rd

  // apply alarm levels and let the registered outputs follow
  task automatic alarms(input logic [7:0] m1, input logic [7:0] m2, input logic [7:0] q1,
    input logic [7:0] q2);
    @(posedge clk);
    mon1 <= m1;
    mon2 <= m2;
    qt1 <= q1;
    qt2 <= q2;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : alarms

  task automatic t_reset();
    wr(OFS_CONTROL, 32'h08, RESP_OKAY);
    rd(OFS_MONITOR_IRQ_ENABLE, 32'h0, RESP_OKAY);
    rd(OFS_QUICKTRIP_ENABLE, 32'h0, RESP_OKAY);
    wr(OFS_RESERVED_A, 32'hff, RESP_OKAY);
    rd(OFS_RESERVED_A, 32'h0, RESP_OKAY);
    rd(OFS_RESERVED_B, 32'h0, RESP_OKAY);
    wr(8'h40, 32'h1, RESP_DECERR);
    rd(8'h44, 32'h0, RESP_DECERR);
  endtask : t_reset

  // every combination of passwords and grants
  task automatic t_access();
    logic [3:0] i;
    logic [7:0] mem;
    logic rok, wok;
    mem = 8'h00;
    for (int k = 0; k < 16; k++)
    begin
      i = k[3:0];
      rok = i[1] || (i[0] && (i[2] || i[3]));
      wok = i[1] || (i[0] && i[3]);
      wr(OFS_CONTROL, {26'h0, i, 2'b00}, RESP_OKAY);
      wr(OFS_MONITOR_IRQ_ENABLE, {24'h0, ~i, i}, wok ? RESP_OKAY : RESP_SLVERR);
      if (wok) mem = {~i, i};
      rd(OFS_MONITOR_IRQ_ENABLE, {24'h0, mem}, rok ? RESP_OKAY : RESP_SLVERR);
    end
    wr(OFS_CONTROL, 32'h0a, RESP_OKAY);
    wr(OFS_MONITOR_IRQ_ENABLE, 32'h55, RESP_SLVERR);
    rd(OFS_QUICKTRIP_ENABLE, 32'h0, RESP_SLVERR);
    wr(OFS_CONTROL, 32'h4a, RESP_OKAY);
    rd(OFS_MONITOR_IRQ_ENABLE, {24'h0, mem}, RESP_OKAY);
  endtask : t_access

  // one enable bit at a time against its own alarm and all others
  task automatic t_monitor();
    logic [7:0] m;
    wr(OFS_CONTROL, 32'h08, RESP_OKAY);
    for (int b = 0; b < 8; b++)
    begin
      m = 8'h01 << b;
      wr(OFS_MONITOR_IRQ_ENABLE, {24'h0, m}, RESP_OKAY);
      alarms(~m, ~m, 8'h0, 8'h0);
      chk("fault1 blocked", {31'h0, fault1}, 32'h0);
      chk("fault2 blocked", {31'h0, fault2}, 32'h0);
      alarms(m, m, 8'h0, 8'h0);
      chk("fault1 passed", {31'h0, fault1}, 32'h1);
      chk("fault2 shared", {31'h0, fault2}, {31'h0, b >= 4});
    end
    wr(OFS_CONTROL, 32'h09, RESP_OKAY);
    rd(OFS_MONITOR_IRQ_ENABLE, 32'h80, RESP_OKAY);
    wr(OFS_MONITOR_IRQ_ENABLE, 32'h3f, RESP_OKAY);
    wr(OFS_CONTROL, 32'h08, RESP_OKAY);
    rd(OFS_MONITOR_IRQ_ENABLE, 32'h30, RESP_OKAY);
    alarms(8'h01, 8'h01, 8'h0, 8'h0);
    chk("fault1 own", {31'h0, fault1}, 32'h0);
    chk("fault2 own", {31'h0, fault2}, 32'h1);
  endtask : t_monitor

  task automatic t_quick();
    wr(OFS_QUICKTRIP_ENABLE, 32'hff, RESP_OKAY);
    rd(OFS_QUICKTRIP_ENABLE, {24'h0, QT_VALID_BITS}, RESP_OKAY);
    for (int b = 0; b < 4; b++)
    begin
      alarms(8'h0, 8'h0, 8'h01 << b, 8'h01 << b);
      chk("gate1", {31'h0, gate1}, {31'h0, QT_VALID_BITS[b]});
      chk("gate2", {31'h0, gate2}, 32'h0);
    end
    wr(OFS_CONTROL, 32'h09, RESP_OKAY);
    wr(OFS_QUICKTRIP_ENABLE, 32'h01, RESP_OKAY);
    wr(OFS_CONTROL, 32'h08, RESP_OKAY);
    rd(OFS_QUICKTRIP_ENABLE, {24'h0, QT_VALID_BITS}, RESP_OKAY);
    alarms(8'h0, 8'h0, 8'h04, 8'h01);
    chk("gate1 rsvd", {31'h0, gate1}, 32'h0);
    chk("gate2 own", {31'h0, gate2}, 32'h1);
  endtask : t_quick

  // sticky status, mask and clear on read
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_IRQ_MASK, 32'h04, RESP_OKAY);
    alarms(8'h0, 8'h0, 8'h0, 8'h0);
    mgmt_host_inst.rd({OFS_IRQ_STATUS, 2'b00}, d, r);
    @(negedge clk);
    chk("irq idle", {31'h0, irq}, 32'h0);
    alarms(8'h0, 8'h0, 8'h01, 8'h0);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h04, RESP_OKAY);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    alarms(8'h0, 8'h0, 8'h0, 8'h0);
    alarms(8'h0, 8'h0, 8'h01, 8'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STATUS, 32'h04, RESP_OKAY);
  endtask : t_irq

  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_access();
    t_monitor();
    t_quick();
    t_irq();
    end_sim();
  end
endmodule : tb_top
